// file: spfg_pkg.sv
// Constants, encodings and carrier types for the self-programming flash guard.
// Assumes a word-addressed program flash behind one system clock domain.
// Functional notes
// - Programming starts only for store commands executed from the boot section.
// - Boot-section stores may target any flash word, limited only by locks.
// - Boot size fuses place the application/boot boundary.
// - Programming a concurrent-read page leaves the core running in stalling section.
// - Programming a stalling-section page halts the core for the whole operation.
// - The boot section always lies wholly inside the stalling section.
// - Busy flag reads one while the concurrent-read section is blocked.
// - Busy flag stays set after programming until software clears it.
// - Writing the read-enable command clears busy and reopens concurrent reads.
// - Two independent two-bit lock fields, application and boot.
// - Lock bits get programmed by software or programmer, cleared by chip erase.
// - General memory lock levels do not affect software stores or loads.
// - Application field mode 1 allows stores and loads to application freely.
// - Application low bit programmed blocks stores to the application section.
// - Application high bit programmed blocks boot-executed loads of application.
// - Application modes 3/4, vectors in boot: no interrupts while in application.
// - Boot field mode 1 allows stores and loads to boot freely.
// - Boot low bit programmed blocks stores to the boot section.
// - Boot high bit programmed blocks application-executed loads of boot.
// - Boot modes 3/4, vectors in application: no interrupts while in boot.
package spfg_pkg;
    // Flash geometry in words
    localparam int ADDR_W = 13;
    localparam logic [ADDR_W-1:0] STALL_START = 13'h1C00;
    // Boot section start per boot size fuse value
    localparam logic [ADDR_W-1:0] BOOT_START_SZ0 = 13'h1C00;
    localparam logic [ADDR_W-1:0] BOOT_START_SZ1 = 13'h1E00;
    localparam logic [ADDR_W-1:0] BOOT_START_SZ2 = 13'h1F00;
    localparam logic [ADDR_W-1:0] BOOT_START_SZ3 = 13'h1F80;
    // Lock data field positions in a lock-set request
    localparam int LOCK_APP_LO = 0;
    localparam int LOCK_APP_HI = 1;
    localparam int LOCK_BOOT_LO = 2;
    localparam int LOCK_BOOT_HI = 3;
    // Unprogrammed lock bits read as one
    localparam logic [1:0] LOCK_UNPROG = 2'h3;

    // Store-program command kinds
    typedef enum logic [2:0] {
        SPM_FILL = 3'h0,
        SPM_ERASE = 3'h1,
        SPM_WRITE = 3'h2,
        SPM_LOCK_SET = 3'h3,
        SPM_READ_EN = 3'h4
    } spfg_spm_kind_t;

    // One store-program request from the core
    typedef struct packed {
        logic valid;
        spfg_spm_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [3:0] lock_data;
    } spfg_spm_req_t;

    // One program-memory load request from the core
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } spfg_lpm_req_t;

    // A two-bit lock field, zero means programmed
    typedef struct packed {
        logic high_bit;
        logic low_bit;
    } spfg_lock_t;

    // Programming sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_PROG_CONC = 2'h1,
        ST_PROG_STALL = 2'h2
    } spfg_state_t;
endpackage

// file: spfg_sect.sv
// Section decoder: maps a word address onto boot and stalling sections.
// Purely combinational; the caller registers whatever it drives out.
`timescale 1ns/1ns
`default_nettype none
module spfg_sect
    import spfg_pkg::*;
(
    // Fuse setting
    input wire logic [1:0] boot_size_fuses,
    // Address under test
    input wire logic [ADDR_W-1:0] addr,
    // Section membership
    output logic in_boot,
    output logic in_stall
);
    logic [ADDR_W-1:0] boot_start;

    // Boundary from fuses, clamped so boot never leaves the stalling part
    always_comb begin
        case (boot_size_fuses)
            2'h0: boot_start = BOOT_START_SZ0;
            2'h1: boot_start = BOOT_START_SZ1;
            2'h2: boot_start = BOOT_START_SZ2;
            default: boot_start = BOOT_START_SZ3;
        endcase
        if (boot_start < STALL_START) begin
            boot_start = STALL_START;
        end
        in_boot = (addr >= boot_start);
        in_stall = (addr >= STALL_START);
    end
endmodule
`default_nettype wire

// file: spfg_lock.sv
// Lock field store for the application and boot sections.
// Nonvolatile contents arrive on nv_lock_bits and are taken while in reset.
`timescale 1ns/1ns
`default_nettype none
module spfg_lock
    import spfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Stored lock image, loaded during reset
    input wire logic [3:0] nv_lock_bits,
    // Software lock-set request
    input wire logic sw_set,
    input wire logic [3:0] sw_data,
    // Serial or parallel programmer
    input wire logic ext_set,
    input wire logic [3:0] ext_data,
    input wire logic chip_erase,
    // Current fields
    output spfg_lock_t app_lock_field,
    output spfg_lock_t boot_lock_field
);
    typedef struct packed {
        spfg_lock_t app;
        spfg_lock_t boot;
    } spfg_lock_st_t;

    spfg_lock_st_t st_r;
    spfg_lock_st_t st_nxt;
    logic [3:0] clr_mask;

    // Bits only move toward programmed; erase or the reset image load moves them back
    always_comb begin
        st_nxt = st_r;
        clr_mask = 4'hF;
        if (sw_set) begin
            clr_mask = clr_mask & sw_data;
        end
        if (ext_set) begin
            clr_mask = clr_mask & ext_data;
        end
        st_nxt.app.low_bit = st_r.app.low_bit & clr_mask[LOCK_APP_LO];
        st_nxt.app.high_bit = st_r.app.high_bit & clr_mask[LOCK_APP_HI];
        st_nxt.boot.low_bit = st_r.boot.low_bit & clr_mask[LOCK_BOOT_LO];
        st_nxt.boot.high_bit = st_r.boot.high_bit & clr_mask[LOCK_BOOT_HI];
        if (chip_erase) begin
            st_nxt.app = LOCK_UNPROG;
            st_nxt.boot = LOCK_UNPROG;
        end
        if (sys_rst) begin
            st_nxt.app = nv_lock_bits[LOCK_APP_HI:LOCK_APP_LO];
            st_nxt.boot = nv_lock_bits[LOCK_BOOT_HI:LOCK_BOOT_LO];
        end
    end

    // Synchronous reset, so the stored image may be taken at reset
    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    assign app_lock_field = st_r.app;
    assign boot_lock_field = st_r.boot;
endmodule
`default_nettype wire

// file: spfg_top.sv
// Self-programming flash guard: decides which store-program and load
// requests reach the flash, sequences erase and write cycles, halts the
// core or blocks concurrent reads while a cycle runs.
// Assumes the core and the flash timer run on clk_sys; no pin inputs.
`timescale 1ns/1ns
`default_nettype none
module spfg_top
    import spfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Fuses and stored locks
    input wire logic [1:0] boot_size_fuses,
    input wire logic [3:0] nv_lock_bits,
    input wire logic ivec_in_boot,
    // External programmer
    input wire logic ext_lock_set,
    input wire logic [3:0] ext_lock_data,
    input wire logic chip_erase,
    // Core side
    input wire logic [ADDR_W-1:0] exec_pc,
    input wire spfg_spm_req_t spm_req,
    input wire spfg_lpm_req_t lpm_req,
    // Flash array side
    input wire logic flash_done,
    output logic flash_start,
    output logic flash_write,
    output logic [ADDR_W-1:0] flash_addr,
    output logic buf_fill,
    output logic buf_clear,
    // Answers to the core
    output logic spm_refused,
    output logic lpm_grant,
    output logic lpm_deny,
    output logic core_halt,
    output logic int_block,
    // Status
    output logic concurrent_read_busy_flag,
    output logic [1:0] app_lock_out,
    output logic [1:0] boot_lock_out
);
    // Whole module state
    typedef struct packed {
        spfg_state_t state;
        logic busy;
        logic halt;
        logic start;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic fill;
        logic clear;
        logic refused;
        logic grant;
        logic deny;
        logic int_blk;
        logic [1:0] app_lk;
        logic [1:0] boot_lk;
    } spfg_top_st_t;

    spfg_top_st_t st_r;
    spfg_top_st_t st_nxt;

    spfg_lock_t app_lock_field;
    spfg_lock_t boot_lock_field;
    logic pc_in_boot;
    logic spm_in_boot;
    logic spm_in_stall;
    logic lpm_in_boot;
    logic lpm_in_stall;
    logic sw_lock_set;
    logic spm_lock_ok;
    logic spm_ok;
    logic lpm_lock_ok;
    logic lpm_conc_hit;

    // Section lookups for the executing PC and both target addresses
    spfg_sect u_sect_pc (
        .boot_size_fuses(boot_size_fuses),
        .addr(exec_pc),
        .in_boot(pc_in_boot),
        .in_stall()
    );

    spfg_sect u_sect_spm (
        .boot_size_fuses(boot_size_fuses),
        .addr(spm_req.addr),
        .in_boot(spm_in_boot),
        .in_stall(spm_in_stall)
    );

    spfg_sect u_sect_lpm (
        .boot_size_fuses(boot_size_fuses),
        .addr(lpm_req.addr),
        .in_boot(lpm_in_boot),
        .in_stall(lpm_in_stall)
    );

    // Lock fields, written by software only through an accepted lock-set
    spfg_lock u_lock (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .nv_lock_bits(nv_lock_bits),
        .sw_set(sw_lock_set),
        .sw_data(spm_req.lock_data),
        .ext_set(ext_lock_set),
        .ext_data(ext_lock_data),
        .chip_erase(chip_erase),
        .app_lock_field(app_lock_field),
        .boot_lock_field(boot_lock_field)
    );

    // Store checks; general memory locks have no input here at all
    always_comb begin
        // Any target allowed from boot, filtered by the target's field
        if (spm_in_boot) begin
            spm_lock_ok = boot_lock_field.low_bit;
        end else begin
            spm_lock_ok = app_lock_field.low_bit;
        end
        // Only boot-resident code may issue commands at all
        spm_ok = spm_req.valid && pc_in_boot && (st_r.state == ST_IDLE);
        sw_lock_set = spm_ok && (spm_req.kind == SPM_LOCK_SET);
    end

    // Load checks: crossing reads gated by the far section's high bit
    always_comb begin
        lpm_lock_ok = 1'b1;
        if (pc_in_boot && !lpm_in_boot) begin
            lpm_lock_ok = app_lock_field.high_bit;
        end
        if (!pc_in_boot && lpm_in_boot) begin
            lpm_lock_ok = boot_lock_field.high_bit;
        end
        // Reads of the blocked section are answered with a refusal
        lpm_conc_hit = st_r.busy && !lpm_in_stall;
    end

    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.start = 1'b0;
        st_nxt.fill = 1'b0;
        st_nxt.clear = 1'b0;
        st_nxt.refused = 1'b0;
        st_nxt.grant = 1'b0;
        st_nxt.deny = 1'b0;
        st_nxt.app_lk = app_lock_field;
        st_nxt.boot_lk = boot_lock_field;

        // Interrupts off while executing in a section locked against vectors
        st_nxt.int_blk = (!app_lock_field.high_bit && ivec_in_boot && !pc_in_boot)
            || (!boot_lock_field.high_bit && !ivec_in_boot && pc_in_boot);

        // Load answers, one cycle after the request
        if (lpm_req.valid) begin
            if (lpm_lock_ok && !lpm_conc_hit) begin
                st_nxt.grant = 1'b1;
            end else begin
                st_nxt.deny = 1'b1;
            end
        end

        case (st_r.state)
            ST_IDLE: begin
                if (spm_req.valid && !spm_ok) begin
                    st_nxt.refused = 1'b1;
                end else if (spm_ok) begin
                    case (spm_req.kind)
                        SPM_ERASE, SPM_WRITE: begin
                            if (spm_lock_ok) begin
                                st_nxt.start = 1'b1;
                                st_nxt.write = (spm_req.kind == SPM_WRITE);
                                st_nxt.addr = spm_req.addr;
                                // Concurrent section is unreadable during any cycle
                                st_nxt.busy = 1'b1;
                                if (spm_in_stall) begin
                                    st_nxt.state = ST_PROG_STALL;
                                    st_nxt.halt = 1'b1;
                                end else begin
                                    st_nxt.state = ST_PROG_CONC;
                                end
                            end else begin
                                st_nxt.refused = 1'b1;
                            end
                        end
                        SPM_FILL: begin
                            st_nxt.fill = 1'b1;
                        end
                        SPM_READ_EN: begin
                            // Clearing is only possible once the cycle is over
                            st_nxt.busy = 1'b0;
                            st_nxt.clear = 1'b1;
                        end
                        SPM_LOCK_SET: begin
                            st_nxt.refused = 1'b0;
                        end
                        default: begin
                            st_nxt.refused = 1'b1;
                        end
                    endcase
                end
            end
            ST_PROG_CONC: begin
                // Core keeps running from the stalling section
                if (spm_req.valid) begin
                    st_nxt.refused = 1'b1;
                end
                if (flash_done) begin
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_PROG_STALL: begin
                if (spm_req.valid) begin
                    st_nxt.refused = 1'b1;
                end
                if (flash_done) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.halt = 1'b0;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
                st_nxt.halt = 1'b0;
            end
        endcase

        if (sys_rst) begin
            st_nxt.state = ST_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.halt = 1'b0;
            st_nxt.start = 1'b0;
            st_nxt.write = 1'b0;
            st_nxt.addr = '0;
            st_nxt.fill = 1'b0;
            st_nxt.clear = 1'b0;
            st_nxt.refused = 1'b0;
            st_nxt.grant = 1'b0;
            st_nxt.deny = 1'b0;
            st_nxt.int_blk = 1'b0;
            st_nxt.app_lk = LOCK_UNPROG;
            st_nxt.boot_lk = LOCK_UNPROG;
        end
    end

    // Single state register, synchronous reset folded into the next state
    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign flash_start = st_r.start;
    assign flash_write = st_r.write;
    assign flash_addr = st_r.addr;
    assign buf_fill = st_r.fill;
    assign buf_clear = st_r.clear;
    assign spm_refused = st_r.refused;
    assign lpm_grant = st_r.grant;
    assign lpm_deny = st_r.deny;
    assign core_halt = st_r.halt;
    assign int_block = st_r.int_blk;
    assign concurrent_read_busy_flag = st_r.busy;
    assign app_lock_out = st_r.app_lk;
    assign boot_lock_out = st_r.boot_lk;
endmodule
`default_nettype wire

// file: spfg_guard_check_properties.sv
// Checker for the flash guard: section, lock, halt and busy relations.
// Sees top-level ports only; bound to every spfg_top at the foot.
`timescale 1ns/1ns
`default_nettype none
module spfg_guard_check
    import spfg_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [1:0] boot_size_fuses,
    input wire logic [ADDR_W-1:0] exec_pc,
    input wire spfg_spm_req_t spm_req,
    input wire spfg_lpm_req_t lpm_req,
    input wire logic flash_done,
    // Outputs under watch
    input wire logic flash_start,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic spm_refused,
    input wire logic buf_clear,
    input wire logic lpm_deny,
    input wire logic core_halt,
    input wire logic concurrent_read_busy_flag,
    input wire logic [1:0] app_lock_out,
    input wire logic [1:0] boot_lock_out
);
    logic [ADDR_W-1:0] bs;
    logic pc_boot;
    logic to_boot;
    logic prog;

    // Own boot start table, so a decoder slip shows up
    always_comb begin
        case (boot_size_fuses)
            2'h0: bs = BOOT_START_SZ0;
            2'h1: bs = BOOT_START_SZ1;
            2'h2: bs = BOOT_START_SZ2;
            default: bs = BOOT_START_SZ3;
        endcase
    end
    // Lock outputs lag the store by two cycles; valid only for settled locks
    assign pc_boot = exec_pc >= bs;
    assign to_boot = spm_req.addr >= bs;
    assign prog = spm_req.valid && spm_req.kind inside {SPM_ERASE, SPM_WRITE};

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_APP_EXEC_REFUSE: assert property (spm_req.valid && !pc_boot |=> spm_refused && !flash_start)
        else $error("store from application section not refused");
    AST_APP_STORE_LOCK: assert property (prog && pc_boot && !to_boot && !app_lock_out[0] |=> spm_refused && !flash_start)
        else $error("locked application store started");
    AST_BOOT_STORE_LOCK: assert property (prog && pc_boot && to_boot && !boot_lock_out[0] |=> spm_refused && !flash_start)
        else $error("locked boot store started");
    AST_CONC_NO_HALT: assert property (flash_start && flash_addr < STALL_START |-> !core_halt)
        else $error("core halted for concurrent-read page");
    AST_STALL_HALT: assert property (flash_start && flash_addr >= STALL_START |-> core_halt ##1 core_halt)
        else $error("core not halted for stalling page");
    AST_HALT_RELEASE: assert property (core_halt && flash_done |=> !core_halt)
        else $error("halt not released after done");
    AST_BUSY_ON_START: assert property (flash_start |-> concurrent_read_busy_flag)
        else $error("busy clear while programming");
    AST_BUSY_KEPT: assert property ($fell(concurrent_read_busy_flag) |-> buf_clear)
        else $error("busy fell without read enable");
    AST_LPM_APP_LOCK: assert property (lpm_req.valid && pc_boot && lpm_req.addr < bs && !app_lock_out[1] |=> lpm_deny)
        else $error("locked application load granted");
    AST_LPM_BOOT_LOCK: assert property (lpm_req.valid && !pc_boot && lpm_req.addr >= bs && !boot_lock_out[1] |=> lpm_deny)
        else $error("locked boot load granted");
endmodule
bind spfg_top spfg_guard_check i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .boot_size_fuses(boot_size_fuses), .exec_pc(exec_pc), .spm_req(spm_req),
    .lpm_req(lpm_req), .flash_done(flash_done), .flash_start(flash_start),
    .flash_addr(flash_addr), .spm_refused(spm_refused), .buf_clear(buf_clear),
    .lpm_deny(lpm_deny), .core_halt(core_halt),
    .concurrent_read_busy_flag(concurrent_read_busy_flag),
    .app_lock_out(app_lock_out), .boot_lock_out(boot_lock_out));
`default_nettype wire

// file: spfg_core_model.sv
// Core model: issues program-store and program-load requests.
// Drives just after a rising edge; each request is valid one cycle.
`timescale 1ns/1ns
`default_nettype none
module spfg_core_model
    import spfg_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Requests
    output logic [ADDR_W-1:0] exec_pc,
    output spfg_spm_req_t spm_req,
    output spfg_lpm_req_t lpm_req
);
    // Idle until the bench asks
    initial begin
        exec_pc = 13'h0000;
        spm_req = '0;
        lpm_req = '0;
    end

    // Store request; address inverted once released, never left stale
    task automatic spm(input logic [ADDR_W-1:0] pc, input spfg_spm_kind_t kd,
                       input logic [ADDR_W-1:0] ad, input logic [3:0] dt);
        @(posedge clk_sys);
        exec_pc <= pc;
        spm_req <= '{1'b1, kd, ad, dt};
        @(posedge clk_sys);
        spm_req <= '{1'b0, kd, ~ad, ~dt};
    endtask

    // Load request; the busy section is read only on purpose
    task automatic lpm(input logic [ADDR_W-1:0] pc, input logic [ADDR_W-1:0] ad);
        @(posedge clk_sys);
        exec_pc <= pc;
        lpm_req <= '{1'b1, ad};
        @(posedge clk_sys);
        lpm_req <= '{1'b0, ~ad};
    endtask
endmodule
`default_nettype wire

// file: self_program_flash_guard_tb.sv
// Bench for the flash guard: a table of single requests, then
// programming, lock and erase sequences by hand.
// Uses spfg_core_model as the core and a flash timer kept here.
`timescale 1ns/1ns
`default_nettype none
module self_program_flash_guard_tb;
    import spfg_pkg::*;
    // Row: fuses, locks, vectors, load, pc, kind, addr, {no,yes,halt,int}
    typedef struct packed {
        logic [1:0] fz;
        logic [3:0] nv;
        logic iv;
        logic ld;
        logic [ADDR_W-1:0] pc;
        spfg_spm_kind_t kd;
        logic [ADDR_W-1:0] ad;
        logic [3:0] ex;
    } spfg_row_t;

    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] boot_size_fuses = 2'h0;
    logic [3:0] nv_lock_bits = 4'hF;
    logic ivec_in_boot = 1'b0;
    logic ext_lock_set = 1'b0;
    logic [3:0] ext_lock_data = 4'hF;
    logic chip_erase = 1'b0;
    logic flash_done = 1'b0;
    logic [4:0] ft_cnt = 5'h00;
    logic [ADDR_W-1:0] exec_pc;
    logic [ADDR_W-1:0] flash_addr;
    spfg_spm_req_t spm_req;
    spfg_lpm_req_t lpm_req;
    logic flash_start, flash_write, buf_fill, buf_clear, spm_refused;
    logic lpm_grant, lpm_deny, core_halt, int_block, busy;
    logic [1:0] app_lock_out;
    logic [1:0] boot_lock_out;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    spfg_row_t rows [15];

    always #50 clk_sys = ~clk_sys;

    spfg_core_model i_core (.clk_sys(clk_sys), .exec_pc(exec_pc), .spm_req(spm_req),
        .lpm_req(lpm_req));

    spfg_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .boot_size_fuses(boot_size_fuses),
        .nv_lock_bits(nv_lock_bits), .ivec_in_boot(ivec_in_boot),
        .ext_lock_set(ext_lock_set), .ext_lock_data(ext_lock_data),
        .chip_erase(chip_erase), .exec_pc(exec_pc), .spm_req(spm_req), .lpm_req(lpm_req),
        .flash_done(flash_done), .flash_start(flash_start), .flash_write(flash_write),
        .flash_addr(flash_addr), .buf_fill(buf_fill), .buf_clear(buf_clear),
        .spm_refused(spm_refused), .lpm_grant(lpm_grant), .lpm_deny(lpm_deny),
        .core_halt(core_halt), .int_block(int_block), .concurrent_read_busy_flag(busy),
        .app_lock_out(app_lock_out), .boot_lock_out(boot_lock_out));

    // Flash timer: done pulse some 20 cycles after each start
    always @(posedge clk_sys) begin
        flash_done <= (ft_cnt == 5'h01);
        if (flash_start === 1'b1) begin
            ft_cnt <= 5'h14;
        end else if (ft_cnt != 5'h00) begin
            ft_cnt <= ft_cnt - 5'h01;
        end
    end

    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic check(input logic [4:0] got, input logic [4:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Fuses and lock image only change under reset
    task automatic reset_dut(input logic [1:0] fz, input logic [3:0] nv, input logic iv);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        boot_size_fuses <= fz;
        nv_lock_bits <= nv;
        ivec_in_boot <= iv;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
    endtask

    // Bounded wait for the done pulse, then the cycle after it
    task automatic wait_done;
        int k;
        k = 0;
        while (flash_done !== 1'b1 && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
    endtask

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        spfg_row_t r;
        logic [4:0] got;
        rows = '{
            '{2'h0, 4'hF, 1'b1, 1'b0, 13'h0100, SPM_ERASE, 13'h0040, 4'h8},
            '{2'h0, 4'hF, 1'b1, 1'b0, 13'h1C10, SPM_ERASE, 13'h0040, 4'h4},
            '{2'h0, 4'hF, 1'b1, 1'b0, 13'h1C10, SPM_WRITE, 13'h1D00, 4'h6},
            '{2'h0, 4'hE, 1'b1, 1'b0, 13'h1C10, SPM_WRITE, 13'h0040, 4'h8},
            '{2'h0, 4'hC, 1'b1, 1'b0, 13'h0100, SPM_FILL, 13'h0000, 4'h9},
            '{2'h0, 4'hB, 1'b0, 1'b0, 13'h1C10, SPM_ERASE, 13'h1D00, 4'h8},
            '{2'h0, 4'h3, 1'b0, 1'b0, 13'h1C10, SPM_ERASE, 13'h1D00, 4'h9},
            '{2'h0, 4'hD, 1'b1, 1'b0, 13'h1C10, SPM_ERASE, 13'h0040, 4'h4},
            '{2'h0, 4'hD, 1'b1, 1'b1, 13'h1C10, SPM_FILL, 13'h0040, 4'h8},
            '{2'h0, 4'hF, 1'b1, 1'b1, 13'h1C10, SPM_FILL, 13'h0040, 4'h4},
            '{2'h0, 4'h7, 1'b0, 1'b1, 13'h0100, SPM_FILL, 13'h1D00, 4'h8},
            '{2'h1, 4'hF, 1'b1, 1'b0, 13'h1DFF, SPM_FILL, 13'h0000, 4'h8},
            '{2'h1, 4'hF, 1'b1, 1'b0, 13'h1E00, SPM_FILL, 13'h0000, 4'h4},
            '{2'h2, 4'hF, 1'b1, 1'b0, 13'h1F00, SPM_FILL, 13'h0000, 4'h4},
            '{2'h3, 4'hF, 1'b1, 1'b0, 13'h1F7F, SPM_FILL, 13'h0000, 4'h8}};
        // Table of single requests, each from a fresh reset
        foreach (rows[i]) begin
            r = rows[i];
            reset_dut(r.fz, r.nv, r.iv);
            if (r.ld) begin
                i_core.lpm(r.pc, r.ad);
            end else begin
                i_core.spm(r.pc, r.kd, r.ad, 4'hF);
            end
            @(negedge clk_sys);
            got = {1'b0, spm_refused | lpm_deny, flash_start | buf_fill | lpm_grant,
                core_halt, int_block};
            check(got, {1'b0, r.ex});
        end
        // Concurrent page erase: loads there refused, busy kept until read-enable
        reset_dut(2'h0, 4'hF, 1'b1);
        i_core.spm(13'h1C10, SPM_ERASE, 13'h0040, 4'hF);
        @(negedge clk_sys);
        check({2'h0, flash_start, flash_write, busy}, 5'h05);
        i_core.lpm(13'h1C10, 13'h0040);
        @(negedge clk_sys);
        check({3'h0, lpm_deny, core_halt}, 5'h02);
        i_core.spm(13'h1C10, SPM_FILL, 13'h0000, 4'hF);
        @(negedge clk_sys);
        check({3'h0, spm_refused, buf_fill}, 5'h02);
        wait_done();
        check({4'h0, busy}, 5'h01);
        i_core.spm(13'h1C10, SPM_READ_EN, 13'h0000, 4'hF);
        @(negedge clk_sys);
        check({3'h0, buf_clear, busy}, 5'h02);
        i_core.lpm(13'h1C10, 13'h0040);
        @(negedge clk_sys);
        check({3'h0, lpm_grant, lpm_deny}, 5'h02);
        // Stalling page write: halt ends with done, busy stays
        reset_dut(2'h0, 4'hF, 1'b1);
        i_core.spm(13'h1C10, SPM_WRITE, 13'h1D05, 4'hF);
        @(negedge clk_sys);
        check({flash_write, flash_addr[3:0]}, 5'h15);
        check(flash_addr[12:8], 5'h1D);
        wait_done();
        check({3'h0, core_halt, busy}, 5'h01);
        // Software set, programmer set, then erase back to unprogrammed
        reset_dut(2'h0, 4'hF, 1'b0);
        i_core.spm(13'h1C10, SPM_LOCK_SET, 13'h0000, 4'hE);
        repeat (2) @(negedge clk_sys);
        check({1'b0, app_lock_out, boot_lock_out}, 5'h0B);
        i_core.spm(13'h1C10, SPM_ERASE, 13'h0040, 4'hF);
        @(negedge clk_sys);
        check({2'h0, spm_refused, flash_start, busy}, 5'h04);
        @(posedge clk_sys);
        ext_lock_set <= 1'b1;
        ext_lock_data <= 4'h7;
        @(posedge clk_sys);
        ext_lock_set <= 1'b0;
        i_core.spm(13'h1C10, SPM_LOCK_SET, 13'h0000, 4'hF);
        repeat (2) @(negedge clk_sys);
        check({1'b0, app_lock_out, boot_lock_out}, 5'h09);
        @(posedge clk_sys);
        chip_erase <= 1'b1;
        @(posedge clk_sys);
        chip_erase <= 1'b0;
        repeat (2) @(negedge clk_sys);
        check({1'b0, app_lock_out, boot_lock_out}, 5'h0F);
        conclude();
    end
endmodule
`default_nettype wire
